// ---- rtl/sensor_status_map.vh ----
// register offsets, field positions, reset values and timing figures of the sensor status block
// assumes a 20 MHz pclk and a 32-bit APB slave with word-aligned registers
// Functional notes
// - actuator gone, both outputs off at once
// - mild fault warns, outputs off after 30 min
// - guard open and close clears the error
// - serial variant resets faults by request bit
// - teach-in at power-up: red on, yellow 1 Hz
// - after 10 s, 3 Hz flashes ask power-off
// - no power-off in 5 min, abort, code five
// - taught code stored only on next detection
// - single-teach variant refuses further teach-in
// - multi-teach unlimited, old code made invalid
// - re-teach blocks outputs ten minutes, green flashes
// - power loss restarts the inhibit from zero
// - yellow steady in range, 1 Hz in limit
// - diagnostic output pulses 2 Hz in limit area
// - red pulse count gives the fault cause
// - internal error switches outputs off at once
// - green lit when supplied and ready
// - diagnostic high only actuated and fault free
// - teach mode: outputs off, green off, red on
// - warning: green off, red flashing, yellow on
// - serial reset on request bit 7 falling
// - warning clears when its cause disappears
// - status bits 0,1,4,5,6,7 as listed
`ifndef SENSOR_STATUS_MAP_VH
`define SENSOR_STATUS_MAP_VH
// register byte offsets
`define REG_STATUS 12'h000
`define REG_CONTROL 12'h004
`define REG_FAULT 12'h008
`define REG_REQUEST 12'h00c
// status fields
`define ST_ENABLED 0
`define ST_DETECTED 1
`define ST_INPUTS 4
`define ST_LIMIT 5
`define ST_WARNING 6
`define ST_ERROR 7
// control fields
`define CT_POWER 0
`define CT_INPUTS 1
`define CT_PRESENT 2
`define CT_LIMIT 3
`define CT_CODE_OK 4
// fault fields
`define FT_OUT_A 0
`define FT_OUT_B 1
`define FT_CROSS 2
`define FT_TEMP 3
`define FT_INTERNAL 5
// request fields
`define RQ_RESET 7
// reset values
`define CONTROL_RESET 8'h00
`define FAULT_RESET 8'h00
`define REQUEST_RESET 8'h00
// timing: tick of 1/12 s (LCM of 1 Hz, 2 Hz, 3 Hz half periods)
`define CLK_HZ 20000000
`define TICK_HZ 12
`define TEACH_S 10
`define ABORT_MIN 5
`define INHIBIT_MIN 10
`define WARN_MIN 30
`endif

// ---- rtl/tick_timer.v ----
// one prescaled timer that counts ticks up to a limit
// assumes a shared one-cycle tick pulse from the parent
`timescale 1ns/100ps
module tick_timer
#(
   parameter WIDTH = 16
)
(
   input wire pclk,
   input wire presetn,
   input wire tick,
   input wire run, // counts while high, clears when low
   input wire [WIDTH-1:0] limit,
   output reg done // level, high once limit ticks reached
);
   reg [WIDTH-1:0] count_q; // elapsed ticks

   ////////////////////////////////////////////////////////////////
   // count ticks, saturate at limit
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         count_q <= {WIDTH{1'b0}};
         done <= 1'b0;
      end
      else if (!run)
      begin
         count_q <= {WIDTH{1'b0}};
         done <= 1'b0;
      end
      else if (tick && !done)
      begin
         count_q <= count_q + {{(WIDTH-1){1'b0}}, 1'b1};
         done <= (count_q + {{(WIDTH-1){1'b0}}, 1'b1}) >= limit;
      end
   end
endmodule // tick_timer

// ---- rtl/sensor_status.v ----
// status, fault, LED and teach-in sequencer of the safety sensor, with an APB register file
// assumes synchronous inputs; the sensor front end is modelled by control register bits
// a shared tick of 1/12 s paces every timer and every flash rate
//
// Register access over APB and the address map were chosen for this implementation.
`timescale 1ns/100ps
`include "sensor_status_map.vh"
module sensor_status
#(
   parameter TICK_DIV = `CLK_HZ / `TICK_HZ, // clocks per tick
   parameter TEACH_TICKS = `TEACH_S * `TICK_HZ,
   parameter ABORT_TICKS = `ABORT_MIN * 60 * `TICK_HZ,
   parameter INHIBIT_TICKS = `INHIBIT_MIN * 60 * `TICK_HZ,
   parameter WARN_TICKS = `WARN_MIN * 60 * `TICK_HZ,
   parameter MULTI_TEACH = 1 // 1: multi_teach_variant, 0: single_teach_variant
)
(
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output wire pready,
   output reg [31:0] prdata,
   output wire pslverr,
   output reg safety_output_a,
   output reg safety_output_b,
   output reg diag_out,
   output reg led_green,
   output reg led_red,
   output reg led_yellow
);
   localparam ST_RUN = 3'h0; // normal operation
   localparam ST_TEACH = 3'h1; // teach-in, waiting 10 s
   localparam ST_ASKOFF = 3'h2; // asking for power-off
   localparam ST_AWAIT = 3'h3; // power back, waiting for detection
   localparam ST_INHIBIT = 3'h4; // protection time
   localparam ST_OFF = 3'h5; // no supply

   //////////////////////////////////////////////////////////////////
   // apb slave: zero wait states, slverr on unmapped address
   reg [7:0] control_q; // simulated supply and sensor front end
   reg [7:0] fault_q; // raw fault causes
   reg [7:0] request_q; // serial request byte
   reg bad_actuator_q; // teach abort flag
   reg error_q; // latched error
   wire [7:0] status_w;
   // decode of the four words; any other address answers with slverr
   wire mapped = (paddr == `REG_STATUS) || (paddr == `REG_CONTROL) ||
      (paddr == `REG_FAULT) || (paddr == `REG_REQUEST);
   wire wr = psel && penable && pwrite && mapped;
   // no wait states: the slave always answers in the first access cycle
   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;

   // register writes
   // writes land at the access edge, ignored for unmapped addresses
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         control_q <= `CONTROL_RESET;
         fault_q <= `FAULT_RESET;
         request_q <= `REQUEST_RESET;
      end
      else if (wr)
      begin
         if (paddr == `REG_CONTROL)
            control_q <= pwdata[7:0];
         if (paddr == `REG_FAULT)
            fault_q <= pwdata[7:0];
         if (paddr == `REG_REQUEST)
            request_q <= pwdata[7:0];
      end
   end

   // read mux, registered on the setup cycle so data is ready at the access
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata <= 32'h00000000;
      else if (psel && !penable)
      begin
         case (paddr)
            `REG_STATUS: prdata <= {24'h000000, status_w};
            `REG_CONTROL: prdata <= {24'h000000, control_q};
            `REG_FAULT: prdata <= {24'h000000, fault_q};
            `REG_REQUEST: prdata <= {24'h000000, request_q};
            default: prdata <= 32'h00000000;
         endcase
      end
   end

   //////////////////////////////////////////////////////////////////
   // tick prescaler and flash phases
   // the divider runs freely, so the first tick after a request may come
   // anywhere within one tick period; every timer is accurate to one tick
   reg [24:0] div_q; // clock divider
   reg tick_q; // one pulse per 1/12 s
   reg [3:0] phase_q; // 0..11 within one second
   reg [3:0] pulse_q; // red pulse code slot, 0..15 half-seconds
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         div_q <= 25'h0000000;
         tick_q <= 1'b0;
         phase_q <= 4'h0;
         pulse_q <= 4'h0;
      end
      else
      begin
         tick_q <= (div_q == TICK_DIV - 1);
         div_q <= (div_q == TICK_DIV - 1) ? 25'h0000000 : div_q + 25'h0000001;
         if (tick_q)
         begin
            phase_q <= (phase_q == 4'hb) ? 4'h0 : phase_q + 4'h1;
            if (phase_q == 4'h5 || phase_q == 4'hb)
               pulse_q <= pulse_q + 4'h1;
         end
      end
   end
   wire blink_1hz = (phase_q < 4'h6);
   wire blink_2hz = (phase_q < 4'h3) || (phase_q >= 4'h6 && phase_q < 4'h9);
   // one tick lit, three dark: short flashes rather than a square wave
   wire blink_3hz = (phase_q[1:0] == 2'b00);

   //////////////////////////////////////////////////////////////////
   // front end and fault classes
   wire power = control_q[`CT_POWER];
   wire present = control_q[`CT_PRESENT];
   // the limit flag only means something while the actuator is seen
   wire limit = control_q[`CT_LIMIT] && present;
   wire inputs = control_q[`CT_INPUTS];
   wire mild = fault_q[`FT_OUT_A] | fault_q[`FT_OUT_B] | fault_q[`FT_CROSS] |
      fault_q[`FT_TEMP];
   wire internal = fault_q[`FT_INTERNAL];
   reg power_q; // previous supply level
   reg present_q; // previous actuator level
   reg req7_q; // previous request bit 7
   wire power_up = power && !power_q;
   wire guard_closed = present && !present_q; // open then closed again
   wire serial_reset = req7_q && !request_q[`RQ_RESET];
   // either way of clearing a fault: guard cycled or request bit falling
   wire fault_clear = guard_closed || serial_reset;

   //////////////////////////////////////////////////////////////////
   // teach sequencer
   // a power loss sends every state back to off; the timers clear with it
   // because their run inputs fall
   reg [2:0] state_q;
   reg stored_q; // code stored permanently
   reg pending_q; // taught code awaiting activation or still in protection time
   wire teach_done;
   wire abort_done;
   wire inhibit_done;
   wire warn_done;
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_q <= ST_OFF;
         stored_q <= 1'b0;
         pending_q <= 1'b0;
         bad_actuator_q <= 1'b0;
         power_q <= 1'b0;
         present_q <= 1'b0;
         req7_q <= 1'b0;
      end
      else
      begin
         power_q <= power;
         present_q <= present;
         req7_q <= request_q[`RQ_RESET];
         if (!power)
            state_q <= ST_OFF; // power loss aborts any timer
         else
         begin
            case (state_q)
               ST_OFF:
               begin
                  // pending code first, then teach, then plain operation
                  if (pending_q)
                     state_q <= ST_AWAIT;
                  else if (present && !control_q[`CT_CODE_OK] &&
                     (MULTI_TEACH != 0 || !stored_q))
                     state_q <= ST_TEACH;
                  else
                     state_q <= ST_RUN;
               end
               ST_TEACH:
                  if (teach_done)
                     state_q <= ST_ASKOFF;
               ST_ASKOFF:
               begin
                  // waits here for the supply to go away
                  pending_q <= 1'b1; // stays pending across the power-off
                  if (abort_done)
                  begin
                     pending_q <= 1'b0;
                     bad_actuator_q <= 1'b1;
                     state_q <= ST_RUN;
                  end
               end
               ST_AWAIT:
                  // pending stays set until the inhibit has run out, so that a
                  // power loss in the protection time comes back here
                  if (present)
                  begin
                     stored_q <= 1'b1; // old code invalid, new kept
                     state_q <= ST_INHIBIT;
                  end
               ST_INHIBIT:
                  if (inhibit_done && present)
                  begin
                     pending_q <= 1'b0; // protection time served
                     state_q <= ST_RUN;
                  end
               ST_RUN:
                  if (guard_closed || serial_reset)
                     bad_actuator_q <= 1'b0;
               default:
                  state_q <= ST_OFF;
            endcase
         end
      end
   end

   // one tick timer per sequence step
   // one timer per step keeps each count simple at the cost of some flops
   // limits are cut to the timer width; defaults stay below 65536 ticks
   tick_timer #(.WIDTH(16)) teach_timer (.pclk(pclk), .presetn(presetn), .tick(tick_q),
      .run(state_q == ST_TEACH), .limit(TEACH_TICKS[15:0]), .done(teach_done));
   tick_timer #(.WIDTH(16)) abort_timer (.pclk(pclk), .presetn(presetn), .tick(tick_q),
      .run(state_q == ST_ASKOFF), .limit(ABORT_TICKS[15:0]), .done(abort_done));
   // inhibit restarts from zero after a power loss
   tick_timer #(.WIDTH(16)) inhibit_timer (.pclk(pclk), .presetn(presetn), .tick(tick_q),
      .run(state_q == ST_INHIBIT), .limit(INHIBIT_TICKS[15:0]), .done(inhibit_done));
   // warning countdown clears to zero when the cause clears
   tick_timer #(.WIDTH(16)) warn_timer (.pclk(pclk), .presetn(presetn), .tick(tick_q),
      .run(mild && power), .limit(WARN_TICKS[15:0]), .done(warn_done));

   //////////////////////////////////////////////////////////////////
   // error latch: set wins over clear
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         error_q <= 1'b0;
      // the abort flag is a level that the same guard edge clears; without the
      // mask it would keep the latch set for good after that edge has passed
      else if (internal || warn_done ||
         (bad_actuator_q && !(fault_clear && state_q == ST_RUN)))
         error_q <= 1'b1;
      else if (fault_clear)
         error_q <= 1'b0;
   end
   wire warning = mild && !error_q;
   wire running = (state_q == ST_RUN) && power;
   wire enable = running && present && !error_q && inputs;

   // red pulse count for the fault cause, 0 means no pulses
   reg [2:0] code_w;
   always @*
   begin
      code_w = 3'h0;
      if (bad_actuator_q)
         code_w = 3'h5;
      else if (fault_q[`FT_OUT_A])
         code_w = 3'h1;
      else if (fault_q[`FT_OUT_B])
         code_w = 3'h2;
      else if (fault_q[`FT_CROSS])
         code_w = 3'h3;
      else if (fault_q[`FT_TEMP])
         code_w = 3'h4;
   end
   // pulse n in the first 2n half-seconds of a 16-slot frame
   // the dark tail of the frame is the pause that separates two codes
   wire red_code = (pulse_q[0] == 1'b0) && (pulse_q[3:1] < code_w);

   //////////////////////////////////////////////////////////////////
   // outputs, all registered
   // both channels carry the same enable; the far side sees a one-cycle lag
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         safety_output_a <= 1'b0;
         safety_output_b <= 1'b0;
         diag_out <= 1'b0;
         led_green <= 1'b0;
         led_red <= 1'b0;
         led_yellow <= 1'b0;
      end
      else
      begin
         safety_output_a <= enable;
         safety_output_b <= enable;
         diag_out <= enable && !warning && (!limit || blink_2hz);
         case (state_q)
            ST_TEACH:
            begin
               led_green <= 1'b0;
               led_red <= 1'b1;
               led_yellow <= blink_1hz;
            end
            ST_ASKOFF:
            begin
               led_green <= 1'b0;
               led_red <= blink_3hz;
               led_yellow <= blink_3hz;
            end
            ST_AWAIT, ST_INHIBIT:
            begin
               led_green <= blink_1hz;
               led_red <= 1'b0;
               led_yellow <= 1'b0;
            end
            ST_RUN:
            begin
               led_green <= !error_q && !warning;
               if (error_q && internal)
                  led_red <= 1'b1;
               else
                  led_red <= (error_q || warning) && red_code;
               led_yellow <= present && (!limit || blink_1hz);
            end
            default:
            begin
               led_green <= 1'b0;
               led_red <= 1'b0;
               led_yellow <= 1'b0;
            end
         endcase
      end
   end

   // status byte
   // bits 2 and 3 are unused and read zero
   assign status_w = {error_q, warning, limit, inputs && power, 2'b00,
      present && running, safety_output_a};
endmodule // sensor_status

// ---- bench/sensor_status_chk.sv ----
// port checker of the sensor status block
// assumes the apb map of sensor_status_map.vh on the rtl include path
`timescale 1ns/100ps
`include "sensor_status_map.vh"
module sensor_status_chk
(
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire pready,
   input wire [31:0] prdata,
   input wire pslverr,
   input wire safety_output_a,
   input wire safety_output_b,
   input wire diag_out,
   input wire led_green,
   input wire led_red,
   input wire led_yellow
);
   reg [7:0] ctl_q; // mirror of the sensor inputs register
   reg [7:0] flt_q; // mirror of the fault register
   wire acc = psel & penable; // access phase
   wire mapped = (paddr <= `REG_REQUEST) && (paddr[1:0] == 2'b00); // four words
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   ////////////////////////////////////////////////////////////////////////////////
   // mirrors follow writes at the access edge, so no body state is needed
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctl_q <= 8'h00;
         flt_q <= 8'h00;
      end
      else if (acc && pwrite && paddr == `REG_CONTROL)
         ctl_q <= pwdata[7:0];
      else if (acc && pwrite && paddr == `REG_FAULT)
         flt_q <= pwdata[7:0];
   end
   ////////////////////////////////////////////////////////////////////////////////
   // four cycles of margin cover the one to two cycle output latency
   absent_off_a: assert property ((!ctl_q[2]) [*4] |-> !safety_output_a && !safety_output_b)
      else $error("safety outputs on without actuator");
   fault_diag_a: assert property ((flt_q != 8'h00) [*4] |-> !diag_out)
      else $error("diagnostic output high during a fault");
   fault_green_a: assert property ((flt_q != 8'h00) [*4] |-> !led_green)
      else $error("green lit during a fault");
   internal_off_a: assert property (flt_q[`FT_INTERNAL] [*4] |-> !safety_output_a)
      else $error("output on during internal error");
   absent_yellow_a: assert property ((!ctl_q[2]) [*4] |-> !led_yellow)
      else $error("yellow lit without actuator");
   unpowered_dark_a: assert property ((!ctl_q[0]) [*4] |-> !led_green && !diag_out)
      else $error("green or diagnostic on without supply");
   unmapped_err_a: assert property (acc && !mapped |-> pslverr)
      else $error("no error response for unmapped address");
   mapped_ok_a: assert property (acc && mapped |-> !pslverr && pready)
      else $error("error response on mapped address");
endmodule // sensor_status_chk

// ---- bench/sensor_far_side.sv ----
// far side model: dual channel monitoring input and the controller diagnostic input
// assumes outputs sampled on pclk, as the monitoring module filters test gaps
`timescale 1ns/100ps
module sensor_far_side
(
   input wire pclk,
   input wire presetn,
   input wire safety_output_a,
   input wire safety_output_b,
   input wire diag_out,
   output reg released, // both channels enabled
   output reg [15:0] diag_pulses // rising edges on the diagnostic input
);
   reg diag_q; // previous diagnostic level
   ////////////////////////////////////////////////////////////////////////////////
   // release needs both channels, one channel alone means stop
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         released <= 1'b0;
         diag_q <= 1'b0;
         diag_pulses <= 16'h0000;
      end
      else
      begin
         released <= safety_output_a & safety_output_b;
         diag_q <= diag_out;
         if (diag_out && !diag_q)
            diag_pulses <= diag_pulses + 16'h0001;
      end
   end
endmodule // sensor_far_side

// ---- bench/tb_top.sv ----
// self-checking bench of the sensor status block
// assumes the rtl include path; timers are shortened by parameters
`timescale 1ns/100ps
`include "sensor_status_map.vh"
module tb_top;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000;
   wire pready, pslverr, sa, sb, diag, g, r, y, released;
   wire [31:0] prdata;
   wire [15:0] diag_pulses;
   logic [31:0] rd; // last read data
   logic er; // last error response
   logic [1:0] fb; // random mild fault bit
   int fail_count = 0;
   int checks = 0;
   int red_n, yel_n, grn_n, d0;
   sensor_status #(.TICK_DIV(4), .TEACH_TICKS(5), .ABORT_TICKS(12), .INHIBIT_TICKS(8),
      .WARN_TICKS(10)) sensor_status_i (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pready(pready), .prdata(prdata), .pslverr(pslverr), .safety_output_a(sa),
      .safety_output_b(sb), .diag_out(diag), .led_green(g), .led_red(r), .led_yellow(y));
   sensor_far_side sensor_far_side_i (.pclk(pclk), .presetn(presetn), .safety_output_a(sa),
      .safety_output_b(sb), .diag_out(diag), .released(released), .diag_pulses(diag_pulses));
   always #25 pclk = ~pclk; // 20 MHz
   ////////////////////////////////////////////////////////////////////////////////
   // expected status word for a taught actuator without latched error, w giving the warning bit
   function automatic logic [31:0] status_of(input logic [7:0] c, input logic w);
      status_of = {24'h0, 1'b0, w, c[3], c[1], 2'b00, c[2], c[2]};
   endfunction
   task check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // one apb transfer; setup, then access held until pready
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 50)
      begin
         @(posedge pclk);
         n++;
      end
      if (n >= 50)
         fail_count++; // no answer within the limit
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task rd_chk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      check(rd & m, exp);
   endtask
   // sample away from the driving edge
   task settle(input int n);
      repeat (n) @(posedge pclk);
      @(negedge pclk);
   endtask
   // rising red edges, yellow and green toggles over n cycles
   task count(input int n);
      logic r0, y0, g0;
      red_n = 0;
      yel_n = 0;
      grn_n = 0;
      r0 = r;
      y0 = y;
      g0 = g;
      repeat (n)
      begin
         @(negedge pclk);
         red_n += (r && !r0);
         yel_n += (y != y0);
         grn_n += (g != g0);
         r0 = r;
         y0 = y;
         g0 = g;
      end
   endtask
   task final_report;
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial
   begin
      void'($urandom(80));
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      rd_chk(`REG_CONTROL, 32'hffffffff, 32'h0);
      rd_chk(`REG_FAULT, 32'hffffffff, 32'h0);
      rd_chk(12'h010, 32'hffffffff, 32'h0);
      check(er, 1'b1);
      apb(1'b1, `REG_CONTROL, 32'h17);
      settle(4);
      check({sa, sb, diag, g, r, y}, 6'b111101);
      rd_chk(`REG_STATUS, 32'hff, status_of(8'h17, 1'b0));
      d0 = diag_pulses;
      apb(1'b1, `REG_CONTROL, 32'h1f);
      count(100);
      check(yel_n > 0, 1'b1);
      check(diag_pulses > d0, 1'b1);
      rd_chk(`REG_STATUS, 32'hff, status_of(8'h1f, 1'b0));
      apb(1'b1, `REG_CONTROL, 32'h13);
      settle(2);
      check({sa, sb}, 2'b00);
      apb(1'b1, `REG_CONTROL, 32'h17);
      fb = $urandom_range(3, 0);
      apb(1'b1, `REG_FAULT, 32'h1 << fb);
      settle(4);
      check({sa, sb, diag, g}, 4'b1100);
      rd_chk(`REG_STATUS, 32'hff, status_of(8'h17, 1'b1));
      apb(1'b1, `REG_FAULT, 32'h0);
      settle(60);
      check({sa, sb, diag}, 3'b111);
      apb(1'b1, `REG_FAULT, 32'h1 << fb);
      settle(60);
      check({sa, sb, released}, 3'b000);
      count(384);
      check(red_n, fb + 1);
      apb(1'b1, `REG_FAULT, 32'h0);
      apb(1'b1, `REG_REQUEST, 32'h80);
      apb(1'b1, `REG_REQUEST, 32'h0);
      settle(4);
      rd_chk(`REG_STATUS, 32'hff, status_of(8'h17, 1'b0));
      apb(1'b1, `REG_FAULT, 32'h20);
      settle(3);
      check({sa, sb, r}, 3'b001);
      count(100);
      check(red_n, 0);
      apb(1'b1, `REG_FAULT, 32'h0);
      apb(1'b1, `REG_CONTROL, 32'h13);
      apb(1'b1, `REG_CONTROL, 32'h17);
      settle(4);
      check({sa, sb}, 2'b11);
      apb(1'b1, `REG_CONTROL, 32'h00);
      apb(1'b1, `REG_CONTROL, 32'h07);
      settle(4);
      check({sa, sb, diag, g, r}, 5'b00001);
      count(60);
      check(yel_n > 0, 1'b1);
      settle(60);
      rd_chk(`REG_STATUS, 32'h80, 32'h80);
      count(384);
      check(red_n, 5);
      // guard cycle clears the teach abort
      apb(1'b1, `REG_CONTROL, 32'h03);
      apb(1'b1, `REG_CONTROL, 32'h07);
      settle(4);
      rd_chk(`REG_STATUS, 32'h80, 32'h0);
      // teach again, then take the supply away while power-off is asked
      apb(1'b1, `REG_CONTROL, 32'h00);
      apb(1'b1, `REG_CONTROL, 32'h07);
      settle(25);
      check({sa, sb, g}, 3'b000);
      count(16);
      check(red_n, 1);
      apb(1'b1, `REG_CONTROL, 32'h06);
      apb(1'b1, `REG_CONTROL, 32'h17);
      settle(4);
      check({sa, sb, diag, r}, 4'b0000);
      // power loss inside the protection time restarts it
      apb(1'b1, `REG_CONTROL, 32'h06);
      apb(1'b1, `REG_CONTROL, 32'h17);
      settle(3);
      count(24);
      check(grn_n > 0, 1'b1);
      check({sa, sb}, 2'b00);
      settle(20);
      check({sa, sb, g}, 3'b111);
      final_report;
   end
   // watchdog against a hung handshake
   initial
   begin
      repeat (20000) @(posedge pclk);
      fail_count++;
      final_report;
   end
endmodule // tb_top
bind sensor_status sensor_status_chk sensor_status_chk_i (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .pready(pready), .prdata(prdata), .pslverr(pslverr), .safety_output_a(safety_output_a),
   .safety_output_b(safety_output_b), .diag_out(diag_out), .led_green(led_green),
   .led_red(led_red), .led_yellow(led_yellow));
